// *** seep_pkg.sv ***
// Package for the two-wire serial EEPROM slave interface.
// Assumes a single 25 MHz system clock; SCL and SDA arrive asynchronously.
package seep_pkg;

    // ------------------------------------------------------------------
    // Geometry and addressing
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 11;
    localparam int          DATA_W        = 8;
    localparam int          PAGE_LOW_W    = 4;
    localparam logic [3:0]  DEV_TYPE_CODE = 4'hA;
    localparam logic [7:0]  MEM_RESET_VAL = 8'hFF;
    localparam logic [10:0] ADDR_RESET    = 11'h000;
    localparam logic [3:0]  BIT_CNT_LAST  = 4'h7;
    localparam logic [3:0]  PAGE_BYTES    = 4'hF;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ      = 25_000_000;
    localparam int WR_TIME_US  = 5000;
    localparam int WR_CYCLES   = WR_TIME_US * (CLK_HZ / 1_000_000);

    // ------------------------------------------------------------------
    // Interface state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ACK,
        ST_WORDADDR,
        ST_WDATA,
        ST_RDATA,
        ST_MACK
    } seep_state_e;

    // Synchronised and edge-decoded bus conditions
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } seep_bus_s;

endpackage : seep_pkg

// *** seep_slave.sv ***
// Two-wire serial EEPROM slave: bus decode, address counter, memory.
// Assumes SCL/SDA come from outside the clock domain and SDA is open-drain.
`timescale 1ns/1ps

// Function
// - Once a stop starts the write cycle, ignore bus and withhold acknowledge.
// - After write cycle completes, acknowledge start plus matching address byte.
// - Acknowledged poll lets master continue with word address or reading.
// - Address counter keeps last accessed address plus one across reads and writes.
// - Current read acknowledges, sends byte at n, counter becomes n+1.
// - Reads increment full address counter right after eighth data bit.
// - Writes advance only low four bits; upper bits stay unchanged.
// - Write command plus word address loads counter for random read.
// - Write command with no data byte only loads address, no write.
// - Each master acknowledge in a read sends the next address byte.
// - Sequential read wraps counter from last address to first.
// - Low supply at stop cancels the pending memory write.
// - Start followed by stop returns interface logic to idle.
// - SDA high in dummy clocks abandons output; next start resets logic.
// - SDA is only driven low or released, never driven high.
// - Device answers only when address upper four bits equal type code.
// - Three bits after type code select one of eight 256-byte blocks.
// - Write starts only if a byte was acknowledged just before stop.
module seep_slave #(
    parameter int WR_CYCLES = seep_pkg::WR_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic low_supply,
    output logic      write_busy
);

    // ------------------------------------------------------------------
    // Input synchronisers and condition detection
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    seep_pkg::seep_bus_s bus;

    // Two flops per pin plus a delay flop; the second and the delay flop feed logic
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    // Start/stop only while SCL stays high
    always_comb
    begin
        bus.scl_rise = scl_sync_reg[1] & ~scl_d_reg;
        bus.scl_fall = ~scl_sync_reg[1] & scl_d_reg;
        bus.start    = scl_sync_reg[1] & scl_d_reg
                       & sda_d_reg & ~sda_sync_reg[1];
        bus.stop     = scl_sync_reg[1] & scl_d_reg
                       & ~sda_d_reg & sda_sync_reg[1];
        bus.sda      = sda_sync_reg[1];
    end

    // ------------------------------------------------------------------
    // Storage and interface state
    // ------------------------------------------------------------------
    logic [seep_pkg::DATA_W-1:0] mem_reg [0:(1<<seep_pkg::ADDR_W)-1];
    logic [seep_pkg::DATA_W-1:0] page_reg [0:15];
    seep_pkg::seep_state_e state_reg, state_next, after_ack_reg, after_ack_next;
    logic [3:0]  bit_cnt_reg, bit_cnt_next;
    logic [7:0]  shift_reg, shift_next;
    logic [10:0] addr_reg, addr_next;
    logic [10:0] wr_base_reg, wr_base_next;
    logic [4:0]  wr_count_reg, wr_count_next;
    logic        byte_acked_reg, byte_acked_next;
    logic        drive_low_reg, drive_low_next;
    logic [31:0] wr_timer_reg, wr_timer_next;
    logic        page_we;
    logic [3:0]  page_idx;
    logic        commit;

    // Decode and counters; the busy timer gates everything else
    always_comb
    begin
        state_next      = state_reg;
        after_ack_next  = after_ack_reg;
        bit_cnt_next    = bit_cnt_reg;
        shift_next      = shift_reg;
        addr_next       = addr_reg;
        wr_base_next    = wr_base_reg;
        wr_count_next   = wr_count_reg;
        byte_acked_next = byte_acked_reg;
        drive_low_next  = drive_low_reg;
        wr_timer_next   = wr_timer_reg;
        page_we         = 1'b0;
        page_idx        = 4'h0;
        commit          = 1'b0;
        if (wr_timer_reg != 32'h0)
        begin
            // Internal write: deaf and mute until the timer runs out
            wr_timer_next  = wr_timer_reg - 32'h1;
            state_next     = seep_pkg::ST_IDLE;
            drive_low_next = 1'b0;
        end
        else if (bus.stop)
        begin
            // Write only if a data byte was acknowledged right before
            if (byte_acked_reg && wr_count_reg != 5'h0
                && !low_supply)
            begin
                commit        = 1'b1;
                wr_timer_next = 32'(WR_CYCLES);
            end
            state_next      = seep_pkg::ST_IDLE;
            drive_low_next  = 1'b0;
            byte_acked_next = 1'b0;
            wr_count_next   = 5'h0;
        end
        else if (bus.start)
        begin
            // Start cancels any command in flight
            state_next      = seep_pkg::ST_DEVADDR;
            bit_cnt_next    = 4'h0;
            drive_low_next  = 1'b0;
            byte_acked_next = 1'b0;
            wr_count_next   = 5'h0;
        end
        else if (bus.scl_rise)
        begin
            unique case (state_reg)
                seep_pkg::ST_DEVADDR, seep_pkg::ST_WORDADDR,
                seep_pkg::ST_WDATA:
                begin
                    shift_next   = {shift_reg[6:0], bus.sda};
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                end
                seep_pkg::ST_MACK:
                begin
                    // Master ack fetches next byte; a released line
                    // (nack or dummy clock) drops the output for good
                    if (!bus.sda)
                    begin
                        state_next   = seep_pkg::ST_RDATA;
                        bit_cnt_next = 4'h0;
                        shift_next   = mem_reg[addr_reg];
                    end
                    else
                        state_next = seep_pkg::ST_IDLE;
                end
                seep_pkg::ST_RDATA: bit_cnt_next = bit_cnt_reg + 4'h1;
                default: ;
            endcase
        end
        else if (bus.scl_fall)
        begin
            drive_low_next = 1'b0;
            byte_acked_next = 1'b0;
            unique case (state_reg)
                seep_pkg::ST_DEVADDR:
                begin
                    if (bit_cnt_reg == 4'h8)
                    begin
                        if (shift_reg[7:4] == seep_pkg::DEV_TYPE_CODE)
                        begin
                            drive_low_next = 1'b1;
                            addr_next[10:8] = shift_reg[3:1];
                            state_next = seep_pkg::ST_ACK;
                            after_ack_next = shift_reg[0] ?
                                seep_pkg::ST_RDATA : seep_pkg::ST_WORDADDR;
                        end
                        else
                            state_next = seep_pkg::ST_IDLE;
                    end
                end
                seep_pkg::ST_WORDADDR:
                begin
                    if (bit_cnt_reg == 4'h8)
                    begin
                        // Dummy write: counter loaded, nothing written
                        addr_next[7:0] = shift_reg;
                        wr_base_next   = {addr_reg[10:8], shift_reg};
                        drive_low_next = 1'b1;
                        state_next     = seep_pkg::ST_ACK;
                        after_ack_next = seep_pkg::ST_WDATA;
                    end
                end
                seep_pkg::ST_WDATA:
                begin
                    if (bit_cnt_reg == 4'h8)
                    begin
                        page_we  = 1'b1;
                        page_idx = addr_reg[3:0];
                        // Only low nibble rolls within the page
                        addr_next[3:0] = addr_reg[3:0] + 4'h1;
                        if (wr_count_reg != 5'h10)
                            wr_count_next = wr_count_reg + 5'h1;
                        drive_low_next  = 1'b1;
                        byte_acked_next = 1'b1;
                        state_next      = seep_pkg::ST_ACK;
                        after_ack_next  = seep_pkg::ST_WDATA;
                    end
                end
                seep_pkg::ST_ACK:
                begin
                    // Ack slot ends; line released, or first read bit driven at once
                    byte_acked_next = byte_acked_reg;
                    state_next   = after_ack_reg;
                    bit_cnt_next = 4'h0;
                    if (after_ack_reg == seep_pkg::ST_RDATA)
                    begin
                        shift_next     = mem_reg[addr_reg];
                        drive_low_next = ~mem_reg[addr_reg][7];
                    end
                end
                seep_pkg::ST_RDATA:
                begin
                    if (bit_cnt_reg == 4'h8)
                    begin
                        // Full 11-bit count wraps past the top
                        addr_next  = addr_reg + 11'h1;
                        state_next = seep_pkg::ST_MACK;
                    end
                    else
                        drive_low_next = ~shift_reg[7 - bit_cnt_reg[2:0]];
                end
                default: ;
            endcase
        end
    end

    // Register the interface state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg      <= seep_pkg::ST_IDLE;
            after_ack_reg  <= seep_pkg::ST_IDLE;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            addr_reg       <= seep_pkg::ADDR_RESET;
            wr_base_reg    <= seep_pkg::ADDR_RESET;
            wr_count_reg   <= 5'h00;
            byte_acked_reg <= 1'b0;
            drive_low_reg  <= 1'b0;
            wr_timer_reg   <= 32'h0;
        end
        else
        begin
            state_reg      <= state_next;
            after_ack_reg  <= after_ack_next;
            bit_cnt_reg    <= bit_cnt_next;
            shift_reg      <= shift_next;
            addr_reg       <= addr_next;
            wr_base_reg    <= wr_base_next;
            wr_count_reg   <= wr_count_next;
            byte_acked_reg <= byte_acked_next;
            drive_low_reg  <= drive_low_next;
            wr_timer_reg   <= wr_timer_next;
        end
    end

    // Page buffer and array; no reset so the array stays plain storage
    always_ff @(posedge clk)
    begin
        if (page_we)
            page_reg[page_idx] <= shift_reg;
        if (commit)
            for (int i = 0; i < 16; i++)
                if (5'(i) < wr_count_reg)
                    mem_reg[{wr_base_reg[10:4],
                             4'(wr_base_reg[3:0] + 4'(i))}] <=
                        page_reg[4'(wr_base_reg[3:0] + 4'(i))];
    end

    // Open-drain: only ever pulls low
    assign sda_out    = 1'b0;
    assign sda_oe     = drive_low_reg;
    assign write_busy = (wr_timer_reg != 32'h0);
endmodule : seep_slave

// *** seep_bus_master.sv ***
// Two-wire bus master model: drives SCL, pulls SDA low only.
// Assumes the bench resolves SDA with a pull-up from all enables.
`timescale 1ns/1ps
module seep_bus_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe
);
    // --------------------------------------------------------
    // Bus primitives, one SCL period is 8 clk (320 ns)
    // --------------------------------------------------------
    initial scl = 1'b1;
    initial sda_oe = 1'b0;
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Start from either SCL level, so it doubles as restart
    task automatic start_c;
        tick(2);
        sda_oe = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b1;   // SDA falls under high SCL
        tick(4);
        scl = 1'b0;
    endtask : start_c
    // SCL then stands high until the next frame
    task automatic stop_c;
        tick(2);
        sda_oe = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b0;   // SDA rises under high SCL
        tick(4);
    endtask : stop_c
    // Data changes only while SCL is low
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_oe = ~b;
        tick(4);
        scl = 1'b1;
        tick(1);
        r = sda;
        tick(1);
        scl = 1'b0;
    endtask : bit_io
    // Byte then ninth slot; ak high releases SDA there
    task automatic xfer(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ak, r);   // Master ack or nack
        acked = ~r;
    endtask : xfer
endmodule : seep_bus_master

// *** seep_slave_properties.sv ***
// Checker for the serial EEPROM slave, bound to its ports.
// Assumes one clock domain; SCL and SDA are seen raw.
`timescale 1ns/1ps
module seep_slave_chk #(
    parameter int WR_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic low_supply,
    input wire logic write_busy
);
    // --------------------------------------------------------
    // Helpers: age of last stop, length of busy period
    // --------------------------------------------------------
    logic        sda_reg, sda_next;
    logic [3:0]  age_reg, age_next;
    logic [31:0] bcnt_reg, bcnt_next;
    // Age saturates so a stale stop never looks fresh
    always_comb
    begin
        sda_next = sda_in;
        age_next = (age_reg == 4'hF) ? 4'hF : age_reg + 4'h1;
        if (scl_in && !sda_reg && sda_in)
            age_next = 4'h0;
        bcnt_next = write_busy ? bcnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_reg  <= 1'b1;
            age_reg  <= 4'hF;
            bcnt_reg <= 32'h0;
        end
        else
        begin
            sda_reg  <= sda_next;
            age_reg  <= age_next;
            bcnt_reg <= bcnt_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_sda_low_only: assert property (sda_out == 1'b0)
        else $error("SDA driven high");
    chk_busy_no_ack: assert property (write_busy |-> !sda_oe)
        else $error("SDA pulled while busy");
    chk_busy_length: assert property ($fell(write_busy) |->
        bcnt_reg + 1 >= WR_CYCLES && bcnt_reg <= WR_CYCLES + 1)
        else $error("busy period length wrong");
    chk_busy_bounded: assert property (bcnt_reg <= WR_CYCLES + 1)
        else $error("busy period too long");
    chk_write_on_stop: assert property
        ($rose(write_busy) |-> age_reg <= 4'h6)
        else $error("write began without stop");
    chk_low_cancel: assert property
        ($rose(write_busy) |-> !low_supply)
        else $error("write began on low supply");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("SDA changed under high SCL");
    chk_stop_idle: assert property (age_reg == 4'h6 |-> !sda_oe)
        else $error("SDA pulled after stop");
    chk_ack_holds: assert property
        ($rose(sda_oe) |=> sda_oe [*3])
        else $error("low drive too short");
    cover property ($rose(write_busy));
    cover property ($rose(sda_oe));
    cover property (age_reg == 4'h0 && low_supply);
endmodule : seep_slave_chk

bind seep_slave seep_slave_chk #(.WR_CYCLES(WR_CYCLES)) chk (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .low_supply(low_supply),
    .write_busy(write_busy));

// *** tb.sv ***
// Self-checking bench for the serial EEPROM slave.
// Assumes the master model in seep_bus_master and a pulled-up SDA.
`timescale 1ns/1ps
module tb;
    // --------------------------------------------------------
    // Wiring: SDA is low while any party pulls it
    // --------------------------------------------------------
    logic       clk, rst_n, low_supply, scl, m_oe, s_oe;
    logic       s_out, busy, ak, r;
    logic [7:0] q;
    wire        sda = m_oe ? 1'b0 : (s_oe ? s_out : 1'b1);
    int         error_cnt = 0;
    int         checked = 0;
    seep_bus_master master (.clk(clk), .sda(sda), .scl(scl),
                            .sda_oe(m_oe));
    seep_slave #(.WR_CYCLES(200)) DUT (.clk(clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(s_out), .sda_oe(s_oe),
        .low_supply(low_supply), .write_busy(busy));
    always #20 clk = ~clk;
    task automatic check(input string what, input logic [7:0] s, e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // --------------------------------------------------------
    // Transfers
    // --------------------------------------------------------
    task automatic dev(input logic [2:0] b, input logic rw, e);
        master.start_c();
        master.xfer({seep_pkg::DEV_TYPE_CODE, b, rw}, 1'b1, q, ak);
        check("address ack", {7'h0, ak}, {7'h0, e});
    endtask : dev
    task automatic seek(input logic [2:0] b, input logic [7:0] wa);
        dev(b, 1'b0, 1'b1);
        master.xfer(wa, 1'b1, q, ak);
        check("word address ack", {7'h0, ak}, 8'h01);
    endtask : seek
    task automatic wr(input logic [2:0] b, input logic [7:0] wa,
                      input logic [7:0] d[$]);
        seek(b, wa);
        foreach (d[i])
        begin
            master.xfer(d[i], 1'b1, q, ak);
            check("data ack", {7'h0, ak}, 8'h01);
        end
        master.stop_c();
    endtask : wr
    // Block bits of the read command replace the counter's top bits
    task automatic rd(input logic [2:0] b, input logic [7:0] e[$]);
        dev(b, 1'b1, 1'b1);
        foreach (e[i])
        begin
            master.xfer(8'hFF, i == e.size() - 1, q, ak);
            check("read data", q, e[i]);
        end
        master.stop_c();
    endtask : rd
    // Read polls; an acked poll still finishes its byte
    task automatic poll_done;
        check("busy at stop", {7'h0, busy}, 8'h01);
        for (int n = 0; n < 20; n++)
        begin
            master.start_c();
            master.xfer(8'hA1, 1'b1, q, ak);
            if (n == 0)
                check("busy poll ack", {7'h0, ak}, 8'h00);
            if (ak)
                master.xfer(8'hFF, 1'b1, q, r);
            master.stop_c();
            if (ak)
                return;
        end
        check("poll never acked", 8'h00, 8'h01);
        wrap_up();
    endtask : poll_done
    // Start, nine released clocks, start, stop
    task automatic recover;
        master.start_c();
        repeat (9)
            master.bit_io(1'b1, r);
        master.start_c();
        master.stop_c();
        check("released", {7'h0, s_oe}, 8'h00);
    endtask : recover
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        low_supply = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        recover();
        wr(3'h7, 8'hFE, '{8'h11});
        poll_done();
        wr(3'h7, 8'hFF, '{8'h22, 8'h55});
        poll_done();
        wr(3'h0, 8'h00, '{8'h33, 8'h44});
        poll_done();
        $display("test writes done");
        seek(3'h7, 8'hFE);
        rd(3'h7, '{8'h11, 8'h22, 8'h33});
        rd(3'h0, '{8'h44});
        seek(3'h7, 8'hF0);
        rd(3'h7, '{8'h55});
        $display("test reads done");
        seek(3'h5, 8'h10);
        master.stop_c();
        check("dummy write busy", {7'h0, busy}, 8'h00);
        low_supply = 1'b1;
        wr(3'h0, 8'h00, '{8'h99});
        check("low supply busy", {7'h0, busy}, 8'h00);
        low_supply = 1'b0;
        seek(3'h0, 8'h00);
        rd(3'h0, '{8'h33});
        master.start_c();
        master.xfer(8'h51, 1'b1, q, ak);
        check("foreign code ack", {7'h0, ak}, 8'h00);
        master.stop_c();
        $display("test guards done");
        dev(3'h0, 1'b1, 1'b1);
        recover();
        seek(3'h0, 8'h01);
        rd(3'h0, '{8'h44});
        $display("test recovery done");
        wrap_up();
    end
endmodule : tb
